// File: design/gt_pkg.sv
// Shared constants and types for the gated 16-bit timer/counter
package gt_pkg;

  // System clock
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Register byte addresses on the APB
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_COUNT_LOW  = 8'h04;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0C;
  localparam logic [7:0] OFF_MASK       = 8'h10;
  localparam logic [7:0] OFF_GATE_SRC   = 8'h14;

  // Field positions
  localparam int ST_OVERFLOW_BIT = 0;
  localparam int GATE_SRC_BIT    = 0;

  // Reset values and count maximum
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  localparam logic        STATUS_RESET   = 1'b0;
  localparam logic        MASK_RESET     = 1'b0;
  localparam logic        GATE_SRC_RESET = 1'b0;

  // Instruction clock is the system clock divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;

  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic       gate_invert;
    logic       gate_enable;
    logic [1:0] prescale_select;
    logic       crystal_osc_enable;
    logic       external_sync_disable;
    logic       clock_source_select;
    logic       timer_on;
  } gt_ctrl_t;

  typedef enum logic [1:0] {
    GT_SRC_INSTR,
    GT_SRC_PIN,
    GT_SRC_CRYSTAL
  } gt_src_t;

  // Prescale terminal mask: 00 -> 1:1, 01 -> 1:2, 10 -> 1:4, 11 -> 1:8
  function automatic logic [2:0] prescale_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    prescale_mask = 3'h0;
      2'h1:    prescale_mask = 3'h1;
      2'h2:    prescale_mask = 3'h3;
      default: prescale_mask = 3'h7;
    endcase
  endfunction : prescale_mask

  // One 32-bit read word from a narrow value
  function automatic logic [31:0] rd_byte(input logic [7:0] v);
    rd_byte = {24'h000000, v};
  endfunction : rd_byte

endpackage : gt_pkg

// File: design/gt_prescale_edge.sv
// Edge detection, synchroniser, arming and prescaler feeding the count
module gt_prescale_edge (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ext_level,
  input  wire logic       use_external,
  input  wire logic       sync_enable,
  input  wire logic       instr_tick,
  input  wire logic       run,
  input  wire logic [1:0] prescale_select,
  input  wire logic       clear_prescale,
  input  wire logic       disarm,
  output logic            count_tick
);

  logic       sync_a;
  logic       sync_b;
  logic       sync_c;
  logic       raw_a;
  logic       raw_b;
  logic       armed;
  logic [2:0] prescale;
  logic       ext_rise;
  logic       ext_low;
  logic       src_edge;

  localparam logic [2:0] PRESCALE_RESET_L = gt_pkg::PRESCALE_RESET;

  // Two-stage synchroniser plus an edge stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= ext_level;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Unsynchronised path skips the synchroniser, so it reacts one cycle sooner
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_a <= 1'b0;
      raw_b <= 1'b0;
    end else begin
      raw_a <= ext_level;
      raw_b <= raw_a;
    end
  end

  always_comb begin
    if (sync_enable) begin
      ext_rise = sync_b & ~sync_c;
      ext_low  = ~sync_b;
    end else begin
      ext_rise = raw_a & ~raw_b;
      ext_low  = ~raw_a;
    end
  end

  // A low level must be seen before the first counted rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (disarm) begin
      armed <= 1'b0;
    end else if (ext_low) begin
      armed <= 1'b1;
    end
  end

  assign src_edge = run & (use_external ? (ext_rise & armed) : instr_tick);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= PRESCALE_RESET_L;
    end else if (clear_prescale) begin
      prescale <= PRESCALE_RESET_L;
    end else if (src_edge) begin
      if ((prescale & gt_pkg::prescale_mask(prescale_select)) ==
          gt_pkg::prescale_mask(prescale_select)) begin
        prescale <= PRESCALE_RESET_L;
      end else begin
        prescale <= prescale + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_tick <= 1'b0;
    end else begin
      count_tick <= src_edge & ~clear_prescale &
                    ((prescale & gt_pkg::prescale_mask(prescale_select)) ==
                     gt_pkg::prescale_mask(prescale_select));
    end
  end

endmodule : gt_prescale_edge

// File: design/gt_timer.sv
// Gated 16-bit timer/counter with APB register access
module gt_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        external_count_clock_pin,
  input  wire logic        crystal_input_pin,
  output logic             crystal_amp_output_pin,
  output logic             crystal_amp_output_oe,
  input  wire logic        internal_osc_no_clkout_mode,
  input  wire logic        sleep_mode,
  input  wire logic        gate_pin,
  input  wire logic        comparator_gate,
  input  wire logic        port_dir_a,
  input  wire logic        port_dir_b,
  input  wire logic        port_data_a,
  input  wire logic        port_data_b,
  output logic             crystal_pin_a_direction,
  output logic             crystal_pin_b_direction,
  output logic             crystal_pin_a_data,
  output logic             crystal_pin_b_data,
  output logic             irq,
  output logic             wake
);

  gt_pkg::gt_ctrl_t ctrl;
  gt_pkg::gt_src_t  src;
  logic [15:0]      count;
  logic             counter_overflow_flag;
  logic             overflow_mask;
  logic             gate_source;
  logic [1:0]       instr_div;
  logic             instr_tick;
  logic             crystal_active;
  logic             ext_level;
  logic             gate_level;
  logic             gate_ok;
  logic             run;
  logic             count_tick;
  logic             timer_on_q;

  logic             access;
  logic             wr_en;
  logic             wr_ctrl;
  logic             wr_low;
  logic             wr_high;
  logic             wr_status;
  logic             wr_mask;
  logic             wr_gate;
  logic             count_write;
  logic             overflow_event;
  logic [31:0]      next_rdata;
  logic             next_err;

  // Register picked by the byte address; one decoder serves reads and writes
  typedef enum logic [2:0] {
    GT_REG_CTRL,
    GT_REG_COUNT_LOW,
    GT_REG_COUNT_HIGH,
    GT_REG_STATUS,
    GT_REG_MASK,
    GT_REG_GATE_SRC,
    GT_REG_NONE
  } gt_reg_t;

  function automatic gt_reg_t decode_reg(input logic [7:0] addr);
    if (addr == gt_pkg::OFF_CTRL) begin
      decode_reg = GT_REG_CTRL;
    end else if (addr == gt_pkg::OFF_COUNT_LOW) begin
      decode_reg = GT_REG_COUNT_LOW;
    end else if (addr == gt_pkg::OFF_COUNT_HIGH) begin
      decode_reg = GT_REG_COUNT_HIGH;
    end else if (addr == gt_pkg::OFF_STATUS) begin
      decode_reg = GT_REG_STATUS;
    end else if (addr == gt_pkg::OFF_MASK) begin
      decode_reg = GT_REG_MASK;
    end else if (addr == gt_pkg::OFF_GATE_SRC) begin
      decode_reg = GT_REG_GATE_SRC;
    end else begin
      decode_reg = GT_REG_NONE;
    end
  endfunction : decode_reg

  gt_reg_t          reg_sel;

  // APB decode

  assign access = psel & penable;
  assign wr_en  = access & pready & pwrite & ~pslverr;
  assign reg_sel = decode_reg(paddr);

  always_comb begin
    wr_ctrl   = 1'b0;
    wr_low    = 1'b0;
    wr_high   = 1'b0;
    wr_status = 1'b0;
    wr_mask   = 1'b0;
    wr_gate   = 1'b0;
    if (reg_sel == GT_REG_CTRL) begin
      wr_ctrl = wr_en;
    end else if (reg_sel == GT_REG_COUNT_LOW) begin
      wr_low = wr_en;
    end else if (reg_sel == GT_REG_COUNT_HIGH) begin
      wr_high = wr_en;
    end else if (reg_sel == GT_REG_STATUS) begin
      wr_status = wr_en;
    end else if (reg_sel == GT_REG_MASK) begin
      wr_mask = wr_en;
    end else if (reg_sel == GT_REG_GATE_SRC) begin
      wr_gate = wr_en;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (reg_sel == GT_REG_CTRL) begin
      next_rdata = gt_pkg::rd_byte(ctrl);
    end else if (reg_sel == GT_REG_COUNT_LOW) begin
      next_rdata = gt_pkg::rd_byte(count[7:0]);
    end else if (reg_sel == GT_REG_COUNT_HIGH) begin
      next_rdata = gt_pkg::rd_byte(count[15:8]);
    end else if (reg_sel == GT_REG_STATUS) begin
      next_rdata = gt_pkg::rd_byte({7'h00, counter_overflow_flag});
    end else if (reg_sel == GT_REG_MASK) begin
      next_rdata = gt_pkg::rd_byte({7'h00, overflow_mask});
    end else if (reg_sel == GT_REG_GATE_SRC) begin
      next_rdata = gt_pkg::rd_byte({7'h00, gate_source});
    end else begin
      next_err = 1'b1;
    end
  end

  // One wait state: data and pready arrive together, so every access takes
  // exactly one extra cycle and read data is registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (access & ~pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= next_err;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Registers written by software

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= gt_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_mask <= gt_pkg::MASK_RESET;
    end else if (wr_mask) begin
      overflow_mask <= pwdata[gt_pkg::ST_OVERFLOW_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_source <= gt_pkg::GATE_SRC_RESET;
    end else if (wr_gate) begin
      gate_source <= pwdata[gt_pkg::GATE_SRC_BIT];
    end
  end

  // Clock source selection

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  assign instr_tick = (instr_div == gt_pkg::INSTR_DIV_LAST);

  // The crystal is shared with the system oscillator, so the enable bit is
  // ignored unless the system clock runs from a mode that leaves it free
  assign crystal_active = ctrl.crystal_osc_enable & internal_osc_no_clkout_mode;

  always_comb begin
    if (!ctrl.clock_source_select) begin
      src = gt_pkg::GT_SRC_INSTR;
    end else if (crystal_active) begin
      src = gt_pkg::GT_SRC_CRYSTAL;
    end else begin
      src = gt_pkg::GT_SRC_PIN;
    end
  end

  always_comb begin
    case (src)
      gt_pkg::GT_SRC_CRYSTAL: ext_level = crystal_input_pin;
      gt_pkg::GT_SRC_PIN:     ext_level = external_count_clock_pin;
      default:                ext_level = 1'b0;
    endcase
  end

  // Gate and run conditions

  assign gate_level = gate_source ? comparator_gate : gate_pin;
  assign gate_ok    = ~ctrl.gate_enable | (ctrl.gate_invert ? gate_level : ~gate_level);

  // In sleep only the unsynchronised external path keeps counting; the
  // instruction clock and the synchroniser both stop with the system clock
  assign run = ctrl.timer_on & gate_ok &
               (~sleep_mode | (ctrl.clock_source_select & ctrl.external_sync_disable));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_on_q <= 1'b0;
    end else begin
      timer_on_q <= ctrl.timer_on;
    end
  end

  assign count_write = wr_low | wr_high;

  // Changing the sync bit mid-count moves the edge detector by one cycle,
  // so one increment can be dropped or doubled at the switch
  gt_prescale_edge u_prescale (
    .pclk            (pclk),
    .presetn         (presetn),
    .ext_level       (ext_level),
    .use_external    (ctrl.clock_source_select),
    .sync_enable     (~ctrl.external_sync_disable),
    .instr_tick      (instr_tick),
    .run             (run),
    .prescale_select (ctrl.prescale_select),
    .clear_prescale  (count_write),
    .disarm          (count_write | ~timer_on_q),
    .count_tick      (count_tick)
  );

  // Count register: a write wins over a coincident increment

  assign overflow_event = count_tick & ~count_write & (count == gt_pkg::COUNT_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= gt_pkg::COUNT_RESET;
    end else if (wr_low) begin
      count[7:0] <= pwdata[7:0];
    end else if (wr_high) begin
      count[15:8] <= pwdata[7:0];
    end else if (count_tick) begin
      count <= count + 16'h0001;
    end
  end

  // Overflow flag: set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_overflow_flag <= gt_pkg::STATUS_RESET;
    end else if (overflow_event) begin
      counter_overflow_flag <= 1'b1;
    end else if (wr_status & pwdata[gt_pkg::ST_OVERFLOW_BIT]) begin
      counter_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= counter_overflow_flag & overflow_mask;
    end
  end

  // Wake only matters while asleep, so it also waits on sleep_mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake <= 1'b0;
    end else begin
      wake <= counter_overflow_flag & overflow_mask & sleep_mode;
    end
  end

  // Crystal pins

  // Amplifier keeps running in sleep; nothing here looks at sleep_mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_amp_output_pin <= 1'b0;
      crystal_amp_output_oe  <= 1'b0;
    end else begin
      crystal_amp_output_pin <= crystal_active & ~crystal_input_pin;
      crystal_amp_output_oe  <= crystal_active;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_pin_a_direction <= 1'b1;
      crystal_pin_b_direction <= 1'b1;
      crystal_pin_a_data      <= 1'b0;
      crystal_pin_b_data      <= 1'b0;
    end else begin
      crystal_pin_a_direction <= crystal_active | port_dir_a;
      crystal_pin_b_direction <= crystal_active | port_dir_b;
      crystal_pin_a_data      <= ~crystal_active & port_data_a;
      crystal_pin_b_data      <= ~crystal_active & port_data_b;
    end
  end

endmodule : gt_timer

// File: test/gt_ext_source.sv
// Far-side clock sources: external count pin and crystal
module gt_ext_source (
  input  wire logic pclk,
  input  wire logic crystal_on,
  output logic      ext_pin,
  output logic      xtal_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] xdiv;

  initial begin
    ext_pin = 1'b0;
    xtal_in = 1'b0;
    xdiv    = 2'h0;
  end

  // Crystal swings only while its amplifier runs, held low otherwise
  always @(posedge pclk) begin
    xdiv <= crystal_on ? xdiv + 2'h1 : 2'h0;
    xtal_in <= crystal_on && (xdiv == 2'h3) ? !xtal_in : (crystal_on && xtal_in);
  end

  // Each pulse is low before high, so a low level always precedes the rise
  task automatic pulse(input int n, input int len);
    repeat (n) begin
      repeat (len) @(posedge pclk);
      ext_pin <= 1'b1;
      repeat (len) @(posedge pclk);
      ext_pin <= 1'b0;
    end
    repeat (6) @(posedge pclk);
  endtask : pulse
endmodule : gt_ext_source

// File: test/gt_timer_props.sv
// Port-level assertions for the gated timer/counter
module gt_timer_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        crystal_input_pin,
  input wire logic        crystal_amp_output_pin,
  input wire logic        crystal_amp_output_oe,
  input wire logic        internal_osc_no_clkout_mode,
  input wire logic        sleep_mode,
  input wire logic        port_dir_a,
  input wire logic        crystal_pin_a_direction,
  input wire logic        crystal_pin_b_direction,
  input wire logic        crystal_pin_a_data,
  input wire logic        crystal_pin_b_data,
  input wire logic        irq,
  input wire logic        wake
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  access_wait_a: assert property (
    psel && $rose(penable) |=> pready) else $error("pready late");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("pready held");
  byte_read_a: assert property (
    pready |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
  err_ready_a: assert property (
    pslverr |-> pready) else $error("pslverr alone");
  amp_invert_a: assert property (
    crystal_amp_output_oe |-> crystal_amp_output_pin == !$past(crystal_input_pin))
    else $error("amp not inverse");
  amp_idle_a: assert property (
    !crystal_amp_output_oe |-> !crystal_amp_output_pin) else $error("amp driven idle");
  osc_mode_a: assert property (
    crystal_amp_output_oe |-> $past(internal_osc_no_clkout_mode))
    else $error("crystal without mode");
  dir_forced_a: assert property (
    crystal_amp_output_oe |-> crystal_pin_a_direction && crystal_pin_b_direction)
    else $error("direction not forced");
  data_zero_a: assert property (
    crystal_amp_output_oe |-> !crystal_pin_a_data && !crystal_pin_b_data)
    else $error("data not zero");
  dir_follow_a: assert property (
    $past(port_dir_a) |-> crystal_pin_a_direction) else $error("direction lost");
  wake_cause_a: assert property (
    wake |-> irq && $past(sleep_mode)) else $error("wake without cause");
endmodule : gt_timer_props

// File: test/gt_timer_tb.sv
// Self-checking bench for the gated timer/counter
module gt_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic rd; logic err; logic [31:0] lo; logic [31:0] hi;} gt_exp_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, wake, gate_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, s;
  logic        external_count_clock_pin, crystal_input_pin, crystal_amp_output_pin;
  logic        crystal_amp_output_oe, internal_osc_no_clkout_mode, sleep_mode;
  logic        comparator_gate, port_dir_a, port_dir_b, port_data_a, port_data_b;
  logic        crystal_pin_a_direction, crystal_pin_b_direction;
  logic        crystal_pin_a_data, crystal_pin_b_data;
  gt_exp_t     exq[$];
  int          n_fail, checks_done;
  integer      seed;

  gt_timer DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .prdata, .pslverr, .external_count_clock_pin, .crystal_input_pin,
    .crystal_amp_output_pin, .crystal_amp_output_oe, .internal_osc_no_clkout_mode,
    .sleep_mode, .gate_pin, .comparator_gate, .port_dir_a, .port_dir_b, .port_data_a,
    .port_data_b, .crystal_pin_a_direction, .crystal_pin_b_direction,
    .crystal_pin_a_data, .crystal_pin_b_data, .irq, .wake);
  gt_ext_source xs (.pclk, .crystal_on(crystal_amp_output_oe),
    .ext_pin(external_count_clock_pin), .xtal_in(crystal_input_pin));

  always #(gt_pkg::CLK_PERIOD_NS / 2) pclk = ~pclk;

  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic miss(input string m);
    n_fail++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask : miss

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] lo, input logic [31:0] hi);
    int t;
    t = 0;
    exq.push_back('{!w, a > gt_pkg::OFF_GATE_SRC, lo, hi});
    {port_dir_a, port_dir_b, port_data_a, port_data_b} <= 4'($random(seed));
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) begin
      miss("no pready");
      wrap_up();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b0, a, 32'h0, lo, hi);
  endtask : rd

  task automatic chk_rd(input gt_exp_t e);
    checks_done++;
    if ((e.rd && (prdata >= e.lo && prdata <= e.hi) !== 1'b1) || pslverr !== e.err) begin
      miss($sformatf("read %0h err %b", prdata, pslverr));
    end
  endtask : chk_rd

  task automatic chk_pin(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miss("output level");
    end
  endtask : chk_pin

  // Scoreboard side: each finished transfer retires the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exq.size() == 0) begin
        miss("unexpected transfer");
      end else begin
        chk_rd(exq.pop_front());
      end
    end
  end

  initial begin
    repeat (100000) @(posedge pclk);
    miss("run too long");
    wrap_up();
  end

  initial begin
    seed = 32'h5E19;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {internal_osc_no_clkout_mode, sleep_mode, gate_pin, comparator_gate} = 4'h0;
    {port_dir_a, port_dir_b, port_data_a, port_data_b} = 4'hF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 8'h18; a += 4) rd(8'(a), 32'h0, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(gt_pkg::OFF_CTRL, {24'h0, 2'h0, 2'(c), 1'b0, 1'(c), 2'h3});
      xs.pulse(3, 2);
      s = 32'($random(seed)) & 32'h0000_00EF;
      wr(gt_pkg::OFF_COUNT_LOW, s);
      xs.pulse(7, 2);
      rd(gt_pkg::OFF_COUNT_LOW, s + (32'h7 >> c), s + (32'h7 >> c));
      wr(gt_pkg::OFF_COUNT_HIGH, ~s);
      rd(gt_pkg::OFF_COUNT_HIGH, {24'h0, ~s[7:0]}, {24'h0, ~s[7:0]});
    end
    wr(gt_pkg::OFF_CTRL, 32'h00);
    wr(gt_pkg::OFF_COUNT_LOW, 32'h00);
    wr(gt_pkg::OFF_CTRL, 32'h01);
    repeat (40) @(posedge pclk);
    rd(gt_pkg::OFF_COUNT_LOW, 32'h09, 32'h0C);
    gate_pin <= 1'b1;
    wr(gt_pkg::OFF_CTRL, 32'h43);
    wr(gt_pkg::OFF_COUNT_LOW, 32'h00);
    xs.pulse(2, 2);
    rd(gt_pkg::OFF_COUNT_LOW, 32'h00, 32'h00);
    gate_pin <= 1'b0;
    xs.pulse(2, 2);
    rd(gt_pkg::OFF_COUNT_LOW, 32'h02, 32'h02);
    comparator_gate <= 1'b1;
    wr(gt_pkg::OFF_GATE_SRC, 32'h01);
    wr(gt_pkg::OFF_CTRL, 32'hC3);
    xs.pulse(2, 2);
    rd(gt_pkg::OFF_COUNT_LOW, 32'h04, 32'h04);
    wr(gt_pkg::OFF_MASK, 32'h01);
    wr(gt_pkg::OFF_CTRL, 32'h07);
    wr(gt_pkg::OFF_COUNT_HIGH, 32'hFF);
    wr(gt_pkg::OFF_COUNT_LOW, 32'hFF);
    sleep_mode <= 1'b1;
    xs.pulse(1, 2);
    chk_pin(irq, 1'b1);
    chk_pin(wake, 1'b1);
    rd(gt_pkg::OFF_COUNT_HIGH, 32'h00, 32'h00);
    rd(gt_pkg::OFF_STATUS, 32'h01, 32'h01);
    wr(gt_pkg::OFF_CTRL, 32'h03);
    xs.pulse(2, 2);
    rd(gt_pkg::OFF_COUNT_LOW, 32'h00, 32'h00);
    sleep_mode <= 1'b0;
    wr(gt_pkg::OFF_MASK, 32'h00);
    @(posedge pclk);
    chk_pin(irq, 1'b0);
    wr(gt_pkg::OFF_STATUS, 32'h01);
    rd(gt_pkg::OFF_STATUS, 32'h00, 32'h00);
    wr(gt_pkg::OFF_CTRL, 32'h08);
    @(posedge pclk);
    chk_pin(crystal_amp_output_oe, 1'b0);
    internal_osc_no_clkout_mode <= 1'b1;
    repeat (20) @(posedge pclk);
    chk_pin(crystal_amp_output_oe, 1'b1);
    wr(gt_pkg::OFF_COUNT_LOW, 32'h00);
    wr(gt_pkg::OFF_CTRL, 32'h0B);
    repeat (80) @(posedge pclk);
    rd(gt_pkg::OFF_COUNT_LOW, 32'h07, 32'h0C);
    repeat (4) @(posedge pclk);
    wrap_up();
  end
endmodule : gt_timer_tb

bind gt_timer gt_timer_props u_props (.pclk, .presetn, .psel, .penable, .pready, .prdata,
  .pslverr, .crystal_input_pin, .crystal_amp_output_pin, .crystal_amp_output_oe,
  .internal_osc_no_clkout_mode, .sleep_mode, .port_dir_a, .crystal_pin_a_direction,
  .crystal_pin_b_direction, .crystal_pin_a_data, .crystal_pin_b_data, .irq, .wake);
